// file: design/jts_map.vh
// Constants for the test access port and serial-wire write-packet logic
// Overview of operation
// - Tester drives TDI, TMS and TCK; TDO is the only output, for chaining.
// - TMS walks the TAP state machine, which picks the register between TDI and TDO.
// - Capture copies the data register into the shifter; update writes it back.
// - A four-bit instruction register selects which data register is shifted.
// - Bypass is one stage linking TDI to TDO.
// - A 32-bit identification register gives maker and part identity.
// - Boundary register has one stage per scanned pin, setting or reading it.
// - External test shifts the boundary register, captures pin values and drives updated ones.
// - Sample shifts the boundary register while normal operation carries on.
// - Preload fills the boundary register in normal mode before external test.
// - Identification instruction puts the identification register in the path.
// - Internal test uses the boundary register on core signals instead of pins.
// - Host always drives the wire clock; data line is driven by either side.
// - Host changes data on falling edges; device samples on the next rising edge.
// - First turnaround is half a clock; device drives acknowledge from rising edges.
// - Second turnaround lasts one and a half clocks with nobody driving.
// - Host adds three low clocks after each packet so the device can finish.
// - Any number of low clocks between packets is treated as idle.
// - Header starts with a one, ends with stop zero then park one.
// - Header parity is even over port select, direction and two address bits.
// - Acknowledge OK 001, WAIT 010, FAULT 100; only FAULT reports an earlier transfer, a data parity error.
// - Address, acknowledge and data travel least significant bit first.
`ifndef JTS_MAP_VH
`define JTS_MAP_VH
`define JTS_IR_W        4
`define JTS_IR_EXTEST   4'h0
`define JTS_IR_SAMPLE   4'h2
`define JTS_IR_PRELOAD  4'h3
`define JTS_IR_IDCODE   4'h4
`define JTS_IR_INTEST   4'h5
`define JTS_IR_BYPASS   4'hf
`define JTS_IR_CAPTURE  4'h1
`define JTS_BSR_W       8
`define JTS_ID_W        32
`define JTS_IDCODE_VAL  32'h10000001
`define JTS_ACK_OK      3'h1
`define JTS_ACK_WAIT    3'h2
`define JTS_ACK_FAULT   3'h4
`define JTS_HDR_LAST    6'h06
`define JTS_DATA_LAST   6'h20
`define JTS_ACK_BITS    2'h3
`define JTS_LINE_RESET  6'h32
`endif

// file: design/jts_test_port.v
// JTAG TAP with boundary scan plus serial-wire write-packet receiver
`timescale 1ns/1ps
`default_nettype none
`include "jts_map.vh"
module jts_test_port #(
    parameter [31:0] ID_VALUE = `JTS_IDCODE_VAL   // Arbitrary identity value, bit 0 set
) (
    input  wire                   sys_clk,
    input  wire                   rst,
    input  wire                   tck,
    input  wire                   tms,
    input  wire                   tdi,
    output wire                   tdo,
    input  wire [`JTS_BSR_W-1:0]  padIn,
    input  wire [`JTS_BSR_W-1:0]  funcOut,
    output wire [`JTS_BSR_W-1:0]  padOut,
    output wire [`JTS_BSR_W-1:0]  coreIn,
    output wire                   testMode,
    input  wire                   serial_wire_clock,
    input  wire                   swdioIn,
    output wire                   swdioOut,
    output wire                   swdioOe_n,
    input  wire                   wrBusy,
    output wire                   wrStrobe,
    output wire [31:0]            wrData,
    output wire [1:0]             wrAddr,
    output wire                   wrPort
);
    // TAP states
    localparam [3:0] TLR = 4'h0, RTI = 4'h1, SDS = 4'h2, CDR = 4'h3;
    localparam [3:0] SDR = 4'h4, E1D = 4'h5, PDR = 4'h6, E2D = 4'h7;
    localparam [3:0] UDR = 4'h8, SIS = 4'h9, CIR = 4'ha, SIR = 4'hb;
    localparam [3:0] E1I = 4'hc, PIR = 4'hd, E2I = 4'he, UIR = 4'hf;
    // Data register selections
    localparam [1:0] SEL_BYP = 2'h0, SEL_ID = 2'h1, SEL_BSR = 2'h2;
    // Serial-wire states
    localparam [2:0] W_LRST = 3'h0, W_IDLE = 3'h1, W_HDR = 3'h2;
    localparam [2:0] W_ACK = 3'h3, W_TRN = 3'h4, W_DATA = 3'h5;

    // Instruction decode, shared by capture, shift length and update
    function [1:0] selOf;
        input [`JTS_IR_W-1:0] ir;
        begin
            case (ir)
                `JTS_IR_EXTEST, `JTS_IR_SAMPLE,
                `JTS_IR_PRELOAD, `JTS_IR_INTEST: selOf = SEL_BSR;
                `JTS_IR_IDCODE:                   selOf = SEL_ID;
                default:                          selOf = SEL_BYP;
            endcase
        end
    endfunction

    // ========================================================
    // Pin synchronisers
    // ========================================================
    reg  [2:0]             tckS_r;
    reg  [1:0]             tmsS_r;
    reg  [1:0]             tdiS_r;
    reg  [2:0]             swcS_r;
    reg  [1:0]             swdS_r;
    reg  [`JTS_BSR_W-1:0]  padS1_r;
    reg  [`JTS_BSR_W-1:0]  padS2_r;
    wire                   tckRise;
    wire                   tckFall;
    wire                   swRise;
    wire                   swBit;

    // Stage 0 feeds stage 1 only; edges come from stages 1 and 2
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tckS_r  <= 3'h0;
            tmsS_r  <= 2'h3;
            tdiS_r  <= 2'h3;
            swcS_r  <= 3'h0;
            swdS_r  <= 2'h0;
            padS1_r <= {`JTS_BSR_W{1'b0}};
            padS2_r <= {`JTS_BSR_W{1'b0}};
        end else begin
            tckS_r  <= {tckS_r[1:0], tck};
            tmsS_r  <= {tmsS_r[0], tms};
            tdiS_r  <= {tdiS_r[0], tdi};
            swcS_r  <= {swcS_r[1:0], serial_wire_clock};
            swdS_r  <= {swdS_r[0], swdioIn};
            padS1_r <= padIn;
            padS2_r <= padS1_r;
        end
    end

    assign tckRise = tckS_r[1] & ~tckS_r[2];
    assign tckFall = ~tckS_r[1] & tckS_r[2];
    assign swRise  = swcS_r[1] & ~swcS_r[2];
    assign swBit   = swdS_r[1];

    // ========================================================
    // TAP controller
    // ========================================================
    reg  [3:0]             tapSt_r;
    reg  [3:0]             tapSt_nxt;
    reg  [`JTS_IR_W-1:0]   irReg_r;
    reg  [`JTS_IR_W-1:0]   irShift_r;
    reg  [31:0]            drShift_r;
    reg  [31:0]            drShift_nxt;
    reg  [31:0]            capVal;
    reg  [`JTS_BSR_W-1:0]  bsrUpd_r;
    reg                    tdo_r;
    reg  [`JTS_BSR_W-1:0]  padOut_r;
    reg  [`JTS_BSR_W-1:0]  coreIn_r;
    wire [1:0]             drSel;
    wire                   inExtest;
    wire                   inIntest;

    assign drSel    = selOf(irReg_r);
    assign inExtest = (irReg_r == `JTS_IR_EXTEST);
    assign inIntest = (irReg_r == `JTS_IR_INTEST);

    // Standard sixteen-state walk, steered by TMS on each TCK rise
    always @* begin
        case (tapSt_r)
            TLR:     tapSt_nxt = tmsS_r[1] ? TLR : RTI;
            RTI:     tapSt_nxt = tmsS_r[1] ? SDS : RTI;
            SDS:     tapSt_nxt = tmsS_r[1] ? SIS : CDR;
            CDR:     tapSt_nxt = tmsS_r[1] ? E1D : SDR;
            SDR:     tapSt_nxt = tmsS_r[1] ? E1D : SDR;
            E1D:     tapSt_nxt = tmsS_r[1] ? UDR : PDR;
            PDR:     tapSt_nxt = tmsS_r[1] ? E2D : PDR;
            E2D:     tapSt_nxt = tmsS_r[1] ? UDR : SDR;
            UDR:     tapSt_nxt = tmsS_r[1] ? SDS : RTI;
            SIS:     tapSt_nxt = tmsS_r[1] ? TLR : CIR;
            CIR:     tapSt_nxt = tmsS_r[1] ? E1I : SIR;
            SIR:     tapSt_nxt = tmsS_r[1] ? E1I : SIR;
            E1I:     tapSt_nxt = tmsS_r[1] ? UIR : PIR;
            PIR:     tapSt_nxt = tmsS_r[1] ? E2I : PIR;
            E2I:     tapSt_nxt = tmsS_r[1] ? UIR : SIR;
            UIR:     tapSt_nxt = tmsS_r[1] ? SDS : RTI;
            default: tapSt_nxt = TLR;
        endcase
    end

    // Capture source and shift step; TDI enters at the top of the active length
    always @* begin
        capVal      = 32'h0;
        drShift_nxt = {1'b0, drShift_r[31:1]};
        case (drSel)
            SEL_ID: begin
                capVal      = ID_VALUE;
                drShift_nxt[`JTS_ID_W-1] = tdiS_r[1];
            end
            SEL_BSR: begin
                // Internal test looks at core drive, the others at the pads
                capVal[`JTS_BSR_W-1:0] = inIntest ? funcOut : padS2_r;
                drShift_nxt[`JTS_BSR_W-1] = tdiS_r[1];
            end
            default: begin
                drShift_nxt[0] = tdiS_r[1];
            end
        endcase
    end

    // TAP registers; TDO moves on the falling edge so the tester samples it on the rise
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tapSt_r   <= TLR;
            irReg_r   <= `JTS_IR_IDCODE;
            irShift_r <= {`JTS_IR_W{1'b0}};
            drShift_r <= 32'h0;
            bsrUpd_r  <= {`JTS_BSR_W{1'b0}};
            tdo_r     <= 1'b0;
        end else begin
            if (tckRise) begin
                tapSt_r <= tapSt_nxt;
                case (tapSt_r)
                    TLR: irReg_r   <= `JTS_IR_IDCODE;
                    CIR: irShift_r <= `JTS_IR_CAPTURE;
                    SIR: irShift_r <= {tdiS_r[1], irShift_r[`JTS_IR_W-1:1]};
                    UIR: irReg_r   <= irShift_r;
                    CDR: drShift_r <= capVal;
                    SDR: drShift_r <= drShift_nxt;
                    UDR: begin
                        if (drSel == SEL_BSR) begin
                            bsrUpd_r <= drShift_r[`JTS_BSR_W-1:0];
                        end
                    end
                    default: tapSt_r <= tapSt_nxt;
                endcase
            end
            if (tckFall) begin
                if (tapSt_r == SIR) begin
                    tdo_r <= irShift_r[0];
                end else if (tapSt_r == SDR) begin
                    tdo_r <= drShift_r[0];
                end
            end
        end
    end

    // Pad and core muxes; pads follow the update stage only under external test
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            padOut_r <= {`JTS_BSR_W{1'b0}};
            coreIn_r <= {`JTS_BSR_W{1'b0}};
        end else begin
            padOut_r <= inExtest ? bsrUpd_r : funcOut;
            coreIn_r <= inIntest ? bsrUpd_r : padS2_r;
        end
    end

    assign tdo      = tdo_r;
    assign padOut   = padOut_r;
    assign coreIn   = coreIn_r;
    assign testMode = inExtest | inIntest;

    // ========================================================
    // Serial-wire write packet
    // ========================================================
    reg  [2:0]   swSt_r;
    reg  [5:0]   bitCnt_r;
    reg  [6:0]   hdr_r;
    reg  [2:0]   ack_r;
    reg          ackOk_r;
    reg          faultPend_r;
    reg  [32:0]  wdat_r;
    reg  [5:0]   highCnt_r;
    reg          swdOut_r;
    reg          swdOe_n_r;
    reg          wrStrobe_r;
    reg  [31:0]  wrData_r;
    reg  [1:0]   wrAddr_r;
    reg          wrPort_r;
    wire [6:0]   hdrFull;
    wire [32:0]  datFull;
    wire         hdrGood;

    assign hdrFull = {swBit, hdr_r[6:1]};
    assign datFull = {swBit, wdat_r[32:1]};
    // Start already seen; check parity over bits 0..4, stop low, park high
    assign hdrGood = ~(^hdrFull[4:0]) & ~hdrFull[5] & hdrFull[6];

    // All wire activity is paced by detected rising edges of the host clock
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            swSt_r      <= W_IDLE;
            bitCnt_r    <= 6'h0;
            hdr_r       <= 7'h0;
            ack_r       <= `JTS_ACK_OK;
            ackOk_r     <= 1'b0;
            faultPend_r <= 1'b0;
            wdat_r      <= 33'h0;
            highCnt_r   <= 6'h0;
            swdOut_r    <= 1'b0;
            swdOe_n_r   <= 1'b1;
            wrStrobe_r  <= 1'b0;
            wrData_r    <= 32'h0;
            wrAddr_r    <= 2'h0;
            wrPort_r    <= 1'b0;
        end else begin
            wrStrobe_r <= 1'b0;
            if (swRise) begin
                // Fifty or more high clocks force a line reset
                highCnt_r <= (swBit && highCnt_r != `JTS_LINE_RESET) ?
                             highCnt_r + 6'h1 : (swBit ? highCnt_r : 6'h0);
                case (swSt_r)
                    W_LRST: begin
                        if (!swBit) begin
                            swSt_r <= W_IDLE;
                        end
                    end
                    W_IDLE: begin
                        if (swBit) begin
                            swSt_r   <= W_HDR;
                            bitCnt_r <= 6'h0;
                        end
                    end
                    W_HDR: begin
                        hdr_r    <= hdrFull;
                        bitCnt_r <= bitCnt_r + 6'h1;
                        if (bitCnt_r == `JTS_HDR_LAST) begin
                            bitCnt_r <= 6'h0;
                            // Bad headers and read requests get no answer
                            if (hdrGood && !hdrFull[1]) begin
                                swSt_r <= W_ACK;
                                if (faultPend_r) begin
                                    ack_r   <= `JTS_ACK_FAULT;
                                    ackOk_r <= 1'b0;
                                end else if (wrBusy) begin
                                    ack_r   <= `JTS_ACK_WAIT;
                                    ackOk_r <= 1'b0;
                                end else begin
                                    ack_r   <= `JTS_ACK_OK;
                                    ackOk_r <= 1'b1;
                                end
                            end else begin
                                swSt_r <= W_IDLE;
                            end
                        end
                    end
                    W_ACK: begin
                        bitCnt_r <= bitCnt_r + 6'h1;
                        if (bitCnt_r[1:0] == `JTS_ACK_BITS) begin
                            swdOe_n_r <= 1'b1;
                            swSt_r    <= W_TRN;
                        end else begin
                            swdOe_n_r <= 1'b0;
                            swdOut_r  <= ack_r[bitCnt_r[1:0]];
                        end
                    end
                    W_TRN: begin
                        // Rise inside the second turnaround carries no data
                        swSt_r   <= W_DATA;
                        bitCnt_r <= 6'h0;
                    end
                    W_DATA: begin
                        wdat_r   <= datFull;
                        bitCnt_r <= bitCnt_r + 6'h1;
                        if (bitCnt_r == `JTS_DATA_LAST) begin
                            swSt_r <= W_IDLE;
                            if (^datFull) begin
                                faultPend_r <= 1'b1;
                            end else if (ackOk_r) begin
                                wrStrobe_r <= 1'b1;
                                wrData_r   <= datFull[31:0];
                                wrAddr_r   <= hdr_r[3:2];
                                wrPort_r   <= hdr_r[0];
                            end
                        end
                    end
                    default: swSt_r <= W_IDLE;
                endcase
                if (swBit && highCnt_r >= `JTS_LINE_RESET - 6'h1) begin
                    swSt_r      <= W_LRST;
                    swdOe_n_r   <= 1'b1;
                    faultPend_r <= 1'b0;
                end
            end
        end
    end

    assign swdioOut  = swdOut_r;
    assign swdioOe_n = swdOe_n_r;
    assign wrStrobe  = wrStrobe_r;
    assign wrData    = wrData_r;
    assign wrAddr    = wrAddr_r;
    assign wrPort    = wrPort_r;
endmodule // jts_test_port
`default_nettype wire

// file: sim/jts_test_port_properties.sv
// Port-level checker for the test access port and serial-wire receiver
`timescale 1ns/1ps
`default_nettype none
`include "jts_map.vh"
module jts_test_port_properties (
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire logic                  tck,
    input wire logic                  tdo,
    input wire logic [`JTS_BSR_W-1:0] funcOut,
    input wire logic [`JTS_BSR_W-1:0] padOut,
    input wire logic                  testMode,
    input wire logic                  serial_wire_clock,
    input wire logic                  swdioOut,
    input wire logic                  swdioOe_n,
    input wire logic                  wrStrobe,
    input wire logic [31:0]           wrData,
    input wire logic [1:0]            wrAddr,
    input wire logic                  wrPort
);
    // ==========================================
    // Helper logic
    logic [7:0] drvCnt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Length of one stretch of device drive; three acknowledge bits at most
    always @(posedge sys_clk or posedge rst) begin
        if (rst) drvCnt <= 8'h00;
        else drvCnt <= swdioOe_n ? 8'h00 : drvCnt + 8'h01;
    end
    sequence driveStart;
        $fell(swdioOe_n);
    endsequence
    sequence driveEnd;
        $rose(swdioOe_n);
    endsequence
    // ==========================================
    // Assertions
    tdo_on_fall_a: assert property ($changed(tdo) |-> !tck)
        else $error("tdo moved while tck high");
    pads_follow_a: assert property (!testMode |=> padOut == $past(funcOut))
        else $error("pads left functional path outside test mode");
    ack_start_a: assert property (driveStart |-> serial_wire_clock)
        else $error("device drive began away from a rising edge");
    ack_release_a: assert property (driveEnd |-> serial_wire_clock)
        else $error("device release away from a rising edge");
    ack_length_a: assert property (drvCnt <= 8'd25)
        else $error("device drove the data line too long");
    ack_change_a: assert property ($changed(swdioOut) |-> serial_wire_clock)
        else $error("drive value changed while wire clock low");
    strobe_pulse_a: assert property (wrStrobe |=> !wrStrobe)
        else $error("write strobe longer than one cycle");
    strobe_released_a: assert property (wrStrobe |-> swdioOe_n)
        else $error("device drove the line during write data");
    write_hold_a: assert property ($changed({wrData, wrAddr, wrPort}) |-> wrStrobe)
        else $error("write outputs changed without a strobe");
endmodule // jts_test_port_properties
bind jts_test_port jts_test_port_properties props (
    .sys_clk(sys_clk), .rst(rst), .tck(tck), .tdo(tdo), .funcOut(funcOut),
    .padOut(padOut), .testMode(testMode), .serial_wire_clock(serial_wire_clock),
    .swdioOut(swdioOut), .swdioOe_n(swdioOe_n), .wrStrobe(wrStrobe),
    .wrData(wrData), .wrAddr(wrAddr), .wrPort(wrPort));
`default_nettype wire

// file: sim/jts_host_model.sv
// Debug host model driving the tester pins and the serial-wire link
`timescale 1ns/1ps
`default_nettype none
module jts_host_model (
    input  wire logic sys_clk,
    output var  logic tck,
    output var  logic tms,
    output var  logic tdi,
    input  wire logic tdo,
    output var  logic serial_wire_clock,
    output var  logic swdioIn,
    input  wire logic swdioOut,
    input  wire logic swdioOe_n,
    output var  logic driveSeen
);
    logic hostEn;
    logic hostBit;
    logic floatBit;
    initial begin
        {tck, tms, tdi, serial_wire_clock, hostBit, floatBit, driveSeen} = 7'h10;
        hostEn = 1'b1;
    end
    // Undriven line wanders every cycle so a stale value is never read back
    always @(posedge sys_clk) begin
        floatBit <= ~floatBit;
        if (!swdioOe_n) driveSeen <= 1'b1;
    end
    // Resolved data line level; both sides driving is flagged unknown
    always_comb begin
        if (!swdioOe_n && hostEn) swdioIn = 1'bx;
        else if (!swdioOe_n) swdioIn = swdioOut;
        else swdioIn = hostEn ? hostBit : floatBit;
    end
    // ==========================================
    // Tester side: pins change while tck low, TDO read before the rise
    task automatic jtick(input logic m, input logic d, output logic q);
        tck = 1'b0;
        tms = m;
        tdi = d;
        #400;
        q = tdo;
        tck = 1'b1;
        #400;
    endtask
    task automatic jreset;
        logic q;
        @(posedge sys_clk);
        #1;
        repeat (5) jtick(1'b1, 1'b0, q);
        jtick(1'b0, 1'b0, q);
    endtask
    // One IR or DR scan from Run-Test-Idle and back, LSB first
    task automatic jscan(input logic ir, input int n, input logic [31:0] din,
                         output logic [31:0] dout);
        logic q;
        int i;
        @(posedge sys_clk);
        #1;
        dout = 32'h0;
        jtick(1'b1, 1'b0, q);
        if (ir) jtick(1'b1, 1'b0, q);
        jtick(1'b0, 1'b0, q);
        jtick(1'b0, 1'b0, q);
        for (i = 0; i < n; i++) begin
            jtick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        jtick(1'b1, 1'b0, q);
        jtick(1'b0, 1'b0, q);
    endtask
    // ==========================================
    // Serial wire: host changes data on the fall, reads on the fall
    task automatic stick(input logic en, input logic b, output logic q);
        q = swdioIn;
        serial_wire_clock = 1'b0;
        hostEn = en;
        hostBit = b;
        #400;
        serial_wire_clock = 1'b1;
        #400;
    endtask
    task automatic swpacket(input logic ap, input logic [1:0] a, input logic [31:0] w,
                            input logic badHdr, input logic badPar, output logic [2:0] ack);
        logic q;
        logic [7:0] hdr;
        int i;
        @(posedge sys_clk);
        #1;
        driveSeen = 1'b0;
        hdr = {1'b1, 1'b0, ap ^ a[0] ^ a[1] ^ badHdr, a[1], a[0], 1'b0, ap, 1'b1};
        repeat (2) stick(1'b1, 1'b0, q);
        for (i = 0; i < 8; i++) stick(1'b1, hdr[i], q);
        stick(1'b0, 1'b0, q);
        for (i = 0; i < 3; i++) begin
            stick(1'b0, 1'b0, q);
            ack[i] = q;
        end
        stick(1'b0, 1'b0, q);
        for (i = 0; i < 32; i++) stick(1'b1, w[i], q);
        stick(1'b1, ^w ^ badPar, q);
        repeat (3) stick(1'b1, 1'b0, q);
    endtask
    task automatic lineReset;
        logic q;
        @(posedge sys_clk);
        #1;
        repeat (50) stick(1'b1, 1'b1, q);
        repeat (3) stick(1'b1, 1'b0, q);
    endtask
endmodule // jts_host_model
`default_nettype wire

// file: sim/jts_test_port_bench.sv
// Self-checking bench for the test access port and serial-wire receiver
`timescale 1ns/1ps
`default_nettype none
`include "jts_map.vh"
module jts_test_port_bench;
    localparam logic [31:0] ID_VALUE = 32'h2a5c3b71; // Arbitrary identity value
    localparam int LIMIT = 40000;
    logic sys_clk, rst, tck, tms, tdi, tdo, testMode, serial_wire_clock;
    logic swdioIn, swdioOut, swdioOe_n, wrBusy, wrStrobe, wrPort, driveSeen;
    logic [7:0] padIn, funcOut, padOut, coreIn;
    logic [31:0] wrData;
    logic [1:0] wrAddr;
    int mismatches, checked, strobes, cycles;
    jts_test_port #(.ID_VALUE(ID_VALUE)) uut (
        .sys_clk(sys_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .padIn(padIn), .funcOut(funcOut), .padOut(padOut), .coreIn(coreIn),
        .testMode(testMode), .serial_wire_clock(serial_wire_clock), .swdioIn(swdioIn),
        .swdioOut(swdioOut), .swdioOe_n(swdioOe_n), .wrBusy(wrBusy), .wrStrobe(wrStrobe),
        .wrData(wrData), .wrAddr(wrAddr), .wrPort(wrPort));
    jts_host_model host (
        .sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .serial_wire_clock(serial_wire_clock), .swdioIn(swdioIn), .swdioOut(swdioOut),
        .swdioOe_n(swdioOe_n), .driveSeen(driveSeen));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // Strobe counter and hang guard
    always @(posedge sys_clk) begin
        if (wrStrobe === 1'b1) strobes <= strobes + 1;
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches = mismatches + 1;
            close_out;
        end
    end
    // ==========================================
    // Shared comparison and verdict
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out;
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================================
    // Scenarios
    task automatic t_idcode;
        logic [31:0] d;
        host.jreset;
        host.jscan(1'b0, 32, 32'h0, d);
        chk("idcode", ID_VALUE, d);
    endtask
    // A known and an unused code must both give the single bypass stage
    task automatic t_bypass;
        logic [31:0] d;
        logic [3:0] codes [2] = '{`JTS_IR_BYPASS, 4'h9};
        foreach (codes[k]) begin
            host.jscan(1'b1, 4, {28'h0, codes[k]}, d);
            chk("ir capture", {28'h0, `JTS_IR_CAPTURE}, d);
            host.jscan(1'b0, 8, 32'hb4, d);
            chk("bypass", 32'h68, d);
        end
    endtask
    task automatic t_boundary;
        logic [31:0] d;
        host.jscan(1'b1, 4, {28'h0, `JTS_IR_SAMPLE}, d);
        host.jscan(1'b0, 8, 32'ha5, d);
        chk("sample capture", 32'h3c, d);
        chk("sample mode", 32'h0, testMode);
        chk("sample pads", 32'h5a, padOut);
        host.jscan(1'b1, 4, {28'h0, `JTS_IR_PRELOAD}, d);
        host.jscan(1'b0, 8, 32'h96, d);
        chk("preload pads", 32'h5a, padOut);
        host.jscan(1'b1, 4, {28'h0, `JTS_IR_EXTEST}, d);
        chk("extest mode", 32'h1, testMode);
        chk("extest pads", 32'h96, padOut);
        host.jscan(1'b0, 8, 32'h69, d);
        chk("extest capture", 32'h3c, d);
        chk("extest update", 32'h69, padOut);
        host.jscan(1'b1, 4, {28'h0, `JTS_IR_INTEST}, d);
        chk("intest mode", 32'h1, testMode);
        chk("intest core", 32'h69, coreIn);
        host.jscan(1'b0, 8, 32'h69, d);
        chk("intest capture", 32'h5a, d);
        host.jscan(1'b1, 4, {28'h0, `JTS_IR_IDCODE}, d);
        chk("normal core", 32'h3c, coreIn);
    endtask
    task automatic t_swd;
        logic [2:0] ack;
        host.swpacket(1'b1, 2'h2, 32'h0, 1'b1, 1'b0, ack);
        chk("bad header drive", 32'h0, driveSeen);
        host.swpacket(1'b1, 2'h2, 32'hc3a51e69, 1'b0, 1'b0, ack);
        chk("ack ok", `JTS_ACK_OK, ack);
        chk("strobes", 32'h1, strobes);
        chk("wdata", 32'hc3a51e69, wrData);
        chk("waddr", 32'h2, wrAddr);
        chk("wport", 32'h1, wrPort);
        host.swpacket(1'b0, 2'h1, 32'h0f0f1234, 1'b0, 1'b1, ack);
        host.swpacket(1'b0, 2'h3, 32'h1, 1'b0, 1'b0, ack);
        chk("ack fault", `JTS_ACK_FAULT, ack);
        chk("strobes", 32'h1, strobes);
        host.lineReset;
        wrBusy = 1'b1;
        host.swpacket(1'b0, 2'h1, 32'h5, 1'b0, 1'b0, ack);
        chk("ack wait", `JTS_ACK_WAIT, ack);
        wrBusy = 1'b0;
        host.swpacket(1'b0, 2'h1, 32'h80000001, 1'b0, 1'b0, ack);
        chk("ack ok", `JTS_ACK_OK, ack);
        chk("strobes", 32'h2, strobes);
        chk("wdata", 32'h80000001, wrData);
        chk("waddr", 32'h1, wrAddr);
        chk("wport", 32'h0, wrPort);
    endtask
    // Main sequence: reset, then tester scans, then serial-wire packets
    initial begin
        {mismatches, checked, strobes, cycles} = '0;
        rst = 1'b1;
        padIn = 8'h3c;
        funcOut = 8'h5a;
        wrBusy = 1'b0;
        repeat (6) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        repeat (4) @(posedge sys_clk);
        t_idcode;
        t_bypass;
        t_boundary;
        t_swd;
        close_out;
    end
endmodule // jts_test_port_bench
`default_nettype wire
